// file: src/drfs_pkg.sv
// package of constants and types for the dram refresh scheduling block
package drfs_pkg;
    localparam int          CLK_MHZ        = 100;
    localparam int          AVERAGE_REFRESH_INTERVAL_BASE_NS  = 7800;
    localparam int          AVERAGE_REFRESH_INTERVAL_CYC      = (AVERAGE_REFRESH_INTERVAL_BASE_NS * CLK_MHZ) / 1000;
    localparam int          REFRESH_CYCLE_TIME_NS        = 260;
    localparam int          REFRESH_CYCLE_TIME_CYC       = (REFRESH_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int          ROW_W          = 17;
    localparam int          DEBT_W         = 8;
    localparam int          MR4_TAR_EN_BIT = 3;
    localparam int          MR4_EXT_BIT    = 2;
    localparam int          MR3_RATE_LSB   = 6;
    localparam int          TEMP_HOT_C     = 85;
    localparam int          TEMP_COOL_C    = 45;
    localparam logic [2:0]  RATE_1X        = 3'h0;
    localparam logic [2:0]  RATE_2X        = 3'h1;
    localparam logic [2:0]  RATE_4X        = 3'h2;
    localparam logic [2:0]  RATE_OTF12     = 3'h5;
    localparam logic [2:0]  RATE_OTF14     = 3'h6;
    typedef enum logic [1:0] {DRFS_IDLE, DRFS_BUSY} drfs_state_t;
endpackage

// file: src/drfs_gear.sv
// temperature gear that decides which registered refreshes run internally
`timescale 1ns/1ps
module drfs_gear (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       ref_pulse,
    input  wire logic       tar_en,
    input  wire logic       ext_range,
    input  wire logic [7:0] temp_c,
    output logic            run_ref
);
    typedef struct packed {
        logic [1:0] ph;
    } drfs_gst_t;
    drfs_gst_t s_q, s_d;
    logic [1:0] ratio;

    always_comb begin
        s_d = s_q;
        ratio = 2'h0;
        if (tar_en) begin
            if (ext_range && temp_c < 8'(drfs_pkg::TEMP_HOT_C))
                ratio = 2'h1;
            if (temp_c < 8'(drfs_pkg::TEMP_COOL_C))
                ratio = ext_range ? 2'h3 : 2'h1;
        end
        // skip all but one in ratio+1 refreshes
        run_ref = ref_pulse && (s_q.ph == 2'h0);
        if (ref_pulse)
            s_d.ph = (s_q.ph >= ratio) ? 2'h0 : s_q.ph + 2'h1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end
endmodule

// file: src/drfs_top.sv
// device-side refresh decode, row counter, lock-out and debt tracking
`timescale 1ns/1ps
module drfs_top #(
    parameter int AVERAGE_REFRESH_INTERVAL_CYCLES = drfs_pkg::AVERAGE_REFRESH_INTERVAL_CYC,
    parameter int REFRESH_CYCLE_TIME_CYCLES  = drfs_pkg::REFRESH_CYCLE_TIME_CYC
) (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RESET_N,
    input  wire logic                      CLK_EN,
    input  wire logic                      CS_N,
    input  wire logic                      ACT_N,
    input  wire logic                      RAS_A16_N,
    input  wire logic                      CAS_A15_N,
    input  wire logic                      WE_A14_N,
    input  wire logic                      BG0,
    input  wire logic [3:0]                MR4,
    input  wire logic [8:0]                MR3,
    input  wire logic [7:0]                TEMP_C,
    output logic                           REF_BUSY,
    output logic                           ROW_VALID,
    output logic [drfs_pkg::ROW_W-1:0]     ROW_ADDR,
    output logic                           BANKS_IDLE,
    output logic                           REFRESH_CYCLE_TIME_VIOL,
    output logic                           DEBT_VIOL,
    output logic signed [drfs_pkg::DEBT_W-1:0] REF_DEBT
);
    typedef struct packed {
        drfs_pkg::drfs_state_t           st;
        logic [15:0]                     rfc_cnt;
        logic [19:0]                     refi_cnt;
        logic [drfs_pkg::ROW_W-1:0]      row;
        logic                            row_v;
        logic                            idle;
        logic                            tviol;
        logic                            dviol;
        logic signed [drfs_pkg::DEBT_W-1:0] debt;
    } drfs_st_t;
    drfs_st_t s_q, s_d;

    logic       ref_cmd, other_cmd, run_ref;
    logic [2:0] rate;
    logic [1:0] shift;
    logic signed [drfs_pkg::DEBT_W-1:0] lim;

    //////////////////////////////////////////////////////////////////////
    // command decode; address pins deliberately not looked at
    assign ref_cmd   = !CS_N && ACT_N && !RAS_A16_N && !CAS_A15_N && WE_A14_N;
    assign other_cmd = !CS_N && !ref_cmd;
    assign rate      = MR3[drfs_pkg::MR3_RATE_LSB +: 3];

    // otf modes pick the rate per command from bg0
    always_comb begin
        shift = 2'h0;
        unique case (rate)
            drfs_pkg::RATE_2X:    shift = 2'h1;
            drfs_pkg::RATE_4X:    shift = 2'h2;
            drfs_pkg::RATE_OTF12: shift = BG0 ? 2'h1 : 2'h0;
            drfs_pkg::RATE_OTF14: shift = BG0 ? 2'h2 : 2'h0;
            default:              shift = 2'h0;
        endcase
        lim = drfs_pkg::DEBT_W'(8) <<< shift;
    end

    drfs_gear u_gear (
        .clk       (CORE_CLK),
        .rst_n     (RESET_N),
        .ce        (CLK_EN),
        .ref_pulse (ref_cmd && s_q.st == drfs_pkg::DRFS_IDLE),
        .tar_en    (MR4[drfs_pkg::MR4_TAR_EN_BIT]),
        .ext_range (MR4[drfs_pkg::MR4_EXT_BIT]),
        .temp_c    (TEMP_C),
        .run_ref   (run_ref)
    );

    //////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.row_v = 1'b0;
        // interval timer scaled by mode; each expiry owes one refresh
        if (s_q.refi_cnt >= 20'((AVERAGE_REFRESH_INTERVAL_CYCLES >> shift) - 1)) begin
            s_d.refi_cnt = '0;
            s_d.debt = s_q.debt + signed'(drfs_pkg::DEBT_W'(1));
        end else begin
            s_d.refi_cnt = s_q.refi_cnt + 20'h1;
        end
        unique case (s_q.st)
            drfs_pkg::DRFS_IDLE: begin
                if (ref_cmd) begin
                    s_d.st = drfs_pkg::DRFS_BUSY;
                    s_d.rfc_cnt = 16'(REFRESH_CYCLE_TIME_CYCLES - 1);
                    s_d.idle = 1'b0;
                    // surplus pull-ins beyond the limit give no credit
                    if (s_d.debt > -lim)
                        s_d.debt = s_d.debt - signed'(drfs_pkg::DEBT_W'(1));
                    if (run_ref) begin
                        s_d.row = s_q.row + 1'b1;
                        s_d.row_v = 1'b1;
                    end
                end
            end
            drfs_pkg::DRFS_BUSY: begin
                if (other_cmd || ref_cmd)
                    s_d.tviol = 1'b1;
                if (s_q.rfc_cnt == '0) begin
                    s_d.st = drfs_pkg::DRFS_IDLE;
                    s_d.idle = 1'b1;
                end else begin
                    s_d.rfc_cnt = s_q.rfc_cnt - 16'h1;
                end
            end
        endcase
        // sticky flag of postponement beyond what the mode allows
        if (s_d.debt > lim)
            s_d.dviol = 1'b1;
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '0;
            s_q.st <= drfs_pkg::DRFS_IDLE;
            s_q.idle <= 1'b1;
        end else if (CLK_EN) begin
            s_q <= s_d;
        end
    end

    assign REF_BUSY   = (s_q.st == drfs_pkg::DRFS_BUSY);
    assign ROW_VALID  = s_q.row_v;
    assign ROW_ADDR   = s_q.row;
    assign BANKS_IDLE = s_q.idle;
    assign REFRESH_CYCLE_TIME_VIOL  = s_q.tviol;
    assign DEBT_VIOL  = s_q.dviol;
    assign REF_DEBT   = s_q.debt;

    //////////////////////////////////////////////////////////////////////
    // lock-out window; needs at least 8 cycles of refresh time
    busy_len_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(REF_BUSY) |-> REF_BUSY [*8])
        else $error("busy dropped early");

    idle_end_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $fell(REF_BUSY) |-> BANKS_IDLE)
        else $error("banks not idle after refresh");

    idle_busy_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        BANKS_IDLE == !REF_BUSY)
        else $error("bank state disagrees with busy");

    ref_start_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && ref_cmd && !REF_BUSY) |=> REF_BUSY)
        else $error("refresh not taken");

    no_take_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && !ref_cmd && !REF_BUSY) |=> !REF_BUSY)
        else $error("refresh started without command");

    take_src_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(REF_BUSY) |-> $past(ref_cmd))
        else $error("busy rose without refresh decode");

    row_step_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ROW_VALID |-> ROW_ADDR == $past(ROW_ADDR) + 1'b1)
        else $error("row counter did not step");

    row_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        !ROW_VALID |-> $stable(ROW_ADDR))
        else $error("row counter moved without refresh");

    tviol_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && REF_BUSY && other_cmd) |=> REFRESH_CYCLE_TIME_VIOL)
        else $error("lock-out breach not flagged");

    ref_viol_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && REF_BUSY && ref_cmd) |=> REFRESH_CYCLE_TIME_VIOL)
        else $error("early refresh not flagged");

    tviol_src_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(REFRESH_CYCLE_TIME_VIOL) |-> $past(REF_BUSY))
        else $error("lock-out flag outside refresh");

    tviol_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $past(REFRESH_CYCLE_TIME_VIOL) |-> REFRESH_CYCLE_TIME_VIOL)
        else $error("lock-out flag not sticky");

    debt_lim_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        REF_DEBT >= -signed'(drfs_pkg::DEBT_W'(32)))
        else $error("credit beyond limit");

    debt_take_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(REF_BUSY) |-> REF_DEBT <= $past(REF_DEBT))
        else $error("refresh raised the debt");

    debt_grow_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        !$rose(REF_BUSY) |-> REF_DEBT >= $past(REF_DEBT))
        else $error("debt fell without refresh");

    dviol_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (REF_DEBT > lim && !$changed(MR3)) |-> DEBT_VIOL)
        else $error("excess debt not flagged");

    dviol_src_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(DEBT_VIOL) |-> REF_DEBT > lim)
        else $error("debt flag below limit");

    dviol_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $past(DEBT_VIOL) |-> DEBT_VIOL)
        else $error("debt flag not sticky");

    busy_row_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ROW_VALID |-> REF_BUSY)
        else $error("row outside refresh");

    row_take_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ROW_VALID |-> $rose(REF_BUSY))
        else $error("row pulse not at refresh start");

    gear_off_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && ref_cmd && !REF_BUSY && !MR4[drfs_pkg::MR4_TAR_EN_BIT]) |=> ROW_VALID)
        else $error("refresh skipped with adaptive off");

    // hot in extended range the gear must not skip
    gear_hot_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && ref_cmd && !REF_BUSY && MR4[drfs_pkg::MR4_TAR_EN_BIT]
            && MR4[drfs_pkg::MR4_EXT_BIT] && TEMP_C >= 8'(drfs_pkg::TEMP_HOT_C)) |=> ROW_VALID)
        else $error("hot extended refresh skipped");

    ref_c: cover property (@(posedge CORE_CLK) $fell(REF_BUSY));
    skip_c: cover property (@(posedge CORE_CLK) $rose(REF_BUSY) && !ROW_VALID);
    viol_c: cover property (@(posedge CORE_CLK) $rose(REFRESH_CYCLE_TIME_VIOL));
    pull_c: cover property (@(posedge CORE_CLK) $rose(REF_BUSY) && REF_DEBT == -lim);
    debt_c: cover property (@(posedge CORE_CLK) $rose(DEBT_VIOL));
endmodule

// file: bench/drfs_ctrl_model.sv
// controller partner that issues refresh commands to the device
`timescale 1ns/1ps
module drfs_ctrl_model #(
    parameter int GAP = 26
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic go,
    input  wire logic early,
    input  wire logic idle,
    output logic      cs_n,
    output logic      act_n,
    output logic      ras_n,
    output logic      cas_n,
    output logic      we_n
);
    int   cnt;
    logic tog;
    ////////////////////////////////////////////////////////////////
    // deselected pins toggle so stale levels never look like a command
    assign act_n = cs_n ? ~tog : 1'h1;
    assign ras_n = cs_n ? tog : 1'h0;
    assign cas_n = cs_n ? ~tog : 1'h0;
    assign we_n  = cs_n ? tog : 1'h1;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            cs_n <= 1'h1;
            tog <= 1'h0;
        end else begin
            tog <= ~tog;
            // early breaks the lock-out on purpose
            if (go && ((cnt == 0 && idle) || early)) begin
                cs_n <= 1'h0;
                cnt <= GAP;
            end else begin
                cs_n <= 1'h1;
                if (cnt != 0) cnt <= cnt - 1;
            end
        end
    end
endmodule

// file: bench/test_dram_refresh_scheduling.sv
// self-checking bench for the refresh decode, lock-out, gear and debt
`timescale 1ns/1ps
module test_dram_refresh_scheduling;
    localparam int REFRESH_CYCLE_TIME = 26;
    logic clk = 1'h0, rst_n = 1'h0, go = 1'h0, early = 1'h0;
    logic [8:0] mr3 = 9'h0;
    logic [3:0] mr4 = 4'h0;
    logic [7:0] temp = 8'h28;
    logic cs_n, act_n, ras_n, cas_n, we_n, busy, rv, idle, tviol, dviol;
    logic [16:0] row;
    logic signed [7:0] debt;
    int fail_count = 0, comparisons = 0, nrv, n;
    always #5 clk = ~clk;
    drfs_ctrl_model #(.GAP(REFRESH_CYCLE_TIME)) ctrl (.clk(clk), .rst_n(rst_n), .go(go), .early(early),
        .idle(idle), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));
    drfs_top #(.AVERAGE_REFRESH_INTERVAL_CYCLES(512), .REFRESH_CYCLE_TIME_CYCLES(REFRESH_CYCLE_TIME)) DUT (.CORE_CLK(clk),
        .RESET_N(rst_n), .CLK_EN(1'h1), .CS_N(cs_n), .ACT_N(act_n), .RAS_A16_N(ras_n),
        .CAS_A15_N(cas_n), .WE_A14_N(we_n), .BG0(1'h0), .MR4(mr4), .MR3(mr3),
        .TEMP_C(temp), .REF_BUSY(busy), .ROW_VALID(rv), .ROW_ADDR(row),
        .BANKS_IDLE(idle), .REFRESH_CYCLE_TIME_VIOL(tviol), .DEBT_VIOL(dviol), .REF_DEBT(debt));
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset(input logic [8:0] m3, input logic [3:0] m4, input logic [7:0] t);
        @(posedge clk);
        rst_n <= 1'h0;
        mr3 <= m3;
        mr4 <= m4;
        temp <= t;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        #1;
        chk({busy, idle, tviol, dviol}, 32'h4);
        chk(row, 32'h0);
        chk({24'h0, debt}, 32'h0);
    endtask
    // leaves the bench in the cycle after the device takes the command
    task automatic send(input logic e);
        @(posedge clk);
        go <= 1'h1;
        early <= e;
        @(posedge clk);
        go <= 1'h0;
        early <= 1'h0;
        @(posedge clk);
        #1;
    endtask
    task automatic ref1;
        send(1'h0);
        chk(busy, 32'h1);
        chk(idle, 32'h0);
        nrv += int'(rv === 1'h1);
        for (n = 1; n < 40; n++) begin
            @(posedge clk);
            #1;
            if (busy !== 1'h1) break;
        end
        if (n == 40) begin
            fail_count++;
            give_verdict();
        end
        chk(n, REFRESH_CYCLE_TIME);
        chk(idle, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_pullin;
        do_reset(9'h0, 4'h0, 8'h28);
        for (int i = 1; i <= 12; i++) begin
            ref1();
            chk(row, i);
        end
        chk({24'h0, debt}, 32'hf8);
    endtask
    task automatic t_gear;
        logic [3:0] gm[6] = '{4'h0, 4'h8, 4'h8, 4'hc, 4'hc, 4'hc};
        logic [7:0] gt[6] = '{8'h1e, 8'h3c, 8'h1e, 8'h3c, 8'h1e, 8'h5a};
        int ge[6] = '{4, 4, 2, 2, 1, 4};
        for (int i = 0; i < 6; i++) begin
            do_reset(9'h0, gm[i], gt[i]);
            nrv = 0;
            repeat (4) ref1();
            chk(nrv, ge[i]);
        end
    endtask
    // no refreshes at all: debt must pass its limit one interval late
    task automatic t_debt;
        int iv, lim;
        for (int s = 0; s < 3; s++) begin
            iv = 512 >> s;
            lim = 8 << s;
            do_reset(9'(s) << 6, 4'h0, 8'h28);
            repeat (lim * iv - 20) @(posedge clk);
            #1;
            chk(dviol, 32'h0);
            repeat (iv + 40) @(posedge clk);
            #1;
            chk(dviol, 32'h1);
        end
    endtask
    task automatic t_viol;
        do_reset(9'h0, 4'h0, 8'h28);
        send(1'h0);
        repeat (3) @(posedge clk);
        send(1'h1);
        chk(tviol, 32'h1);
        chk(row, 32'h1);
    endtask
    initial begin
        t_pullin();
        t_gear();
        t_debt();
        t_viol();
        give_verdict();
    end
endmodule
